// ---- src/spr_map.svh ----
// register offsets, field positions, reset values and timing counts of the serial register port
`ifndef SPR_MAP_SVH
`define SPR_MAP_SVH
// ***********************************************
// frame layout: read flag, 7-bit address, 8-bit data
// ***********************************************
`define SPR_FRAME_BITS    16
`define SPR_HDR_BITS      8
`define SPR_RW_BIT        7
// ***********************************************
// device register offsets (7-bit address space)
// ***********************************************
`define SPR_DEV_PINCFG    7'h00
`define SPR_DEV_STATUS    7'h01
`define SPR_DEV_MASK      7'h02
`define SPR_DEV_USER      7'h03
// interrupt_pin_config fields
`define SPR_PIN_POL       0
`define SPR_PIN_OD        1
`define SPR_PIN_GPO       2
`define SPR_PIN_GPOVAL    3
`define SPR_PINCFG_RST    8'h01
`define SPR_USER_RST      8'h00
// ***********************************************
// controller register offsets (4-bit address space)
// ***********************************************
`define SPR_HST_CMD       4'h0
`define SPR_HST_RXDATA    4'h1
`define SPR_HST_STATUS    4'h2
`define SPR_HST_MASK      4'h3
`define SPR_HST_MODE      4'h4
`define SPR_HST_STATE     4'h5
`define SPR_CMD_READ      15
`define SPR_ST_DONE       0
`define SPR_ST_PINCHG     1
`define SPR_MODE_CPOL     0
`define SPR_MODE_CPHA     1
`define SPR_MODE_RST      2'h0
// ***********************************************
// timing: serial clock half period in clk cycles
// ***********************************************
`define SPR_HALF_DEFAULT  8
`define SPR_HALF_MIN      6
`endif

// ---- src/spr_pkg.sv ----
// types shared by the serial register port ends
package spr_pkg;
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_RUN, H_HOLD} spr_hstate_t;
  typedef logic [7:0] spr_byte_t;
endpackage

// ---- src/spr_if.sv ----
// serial link and interrupt pin between controller and device
`timescale 1ns/1ps
interface spr_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic cpol;
  logic cpha;
  logic irq_out;
  logic irq_oe;
  logic sdo_wire;
  logic irq_wire;

  // undriven lines float high through pull-ups
  assign sdo_wire = sdo_oe ? sdo : 1'b1;
  assign irq_wire = irq_oe ? irq_out : 1'b1;

  modport dev (input cs_n, sclk, sdi, cpol, cpha, output sdo, sdo_oe, irq_out, irq_oe);
  modport host (output cs_n, sclk, sdi, cpol, cpha, input sdo_wire, irq_wire);
endinterface

// ---- src/spr_sync.sv ----
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module spr_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("spr_sync width must be at least 1");
    end
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          meta[i] <= INIT[i];
          q[i]    <= INIT[i];
        end else begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate
endmodule // spr_sync

// ---- src/spr_device.sv ----
// device end: serial register port slave with configurable interrupt pin
// How it works
// - serial pins act only in serial mode
// - master holds chip select low whole transfer
// - master alone sources the serial clock
// - command, address, write data on input
// - read data leaves on data output
// - phase 0 leading latch, 1 trailing
// - polarity 0 idles low, 1 high
// - interrupt pin polarity set by configuration
// - interrupt pin push-pull or open-drain
// - pin may serve as general output
`timescale 1ns/1ps
`include "spr_map.svh"
module spr_device
  import spr_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset,
  input  wire logic   spi_mode_en,
  input  wire logic   [3:0] event_in,
  output logic        [7:0] user_ctrl,
  spr_if.dev          link
);
  // ***********************************************
  // pin synchronisation
  // ***********************************************
  logic       cs_n_s;
  logic       sclk_s;
  logic       sdi_s;
  logic       cpol_s;
  logic       cpha_s;
  logic       sclk_prev;

  // sclk is only sampled; the device never drives it
  spr_sync #(.WIDTH(5), .INIT(5'h10)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({link.cs_n, link.sclk, link.sdi, link.cpol, link.cpha}),
    .q     ({cs_n_s, sclk_s, sdi_s, cpol_s, cpha_s})
  );

  // ***********************************************
  // edge classification
  // ***********************************************
  wire active     = spi_mode_en & ~cs_n_s;
  wire sclk_edge  = active & (sclk_s ^ sclk_prev);
  wire leading    = sclk_s != cpol_s;
  wire sample_eg  = sclk_edge & (leading ^ cpha_s);
  wire shift_eg   = sclk_edge & ~(leading ^ cpha_s);

  // ***********************************************
  // frame shifting
  // ***********************************************
  logic [4:0]  bitcnt;
  logic [7:0]  rxsh;
  logic [7:0]  hdr;
  logic [7:0]  txd;
  wire  [7:0]  rx_byte   = {rxsh[6:0], sdi_s};
  wire         hdr_done  = sample_eg && bitcnt == 5'(`SPR_HDR_BITS - 1);
  wire         data_done = sample_eg && bitcnt == 5'(`SPR_FRAME_BITS - 1);
  wire         in_data   = bitcnt >= 5'(`SPR_HDR_BITS) && bitcnt < 5'(`SPR_FRAME_BITS);
  wire         is_read   = hdr[`SPR_RW_BIT];
  wire         wr_en     = data_done & ~is_read;
  wire  [6:0]  wr_addr   = hdr[6:0];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bitcnt <= 5'h00;
      rxsh   <= 8'h00;
    end else if (!active) begin
      bitcnt <= 5'h00;
    end else if (sample_eg) begin
      rxsh   <= rx_byte;
      // bits past one frame are ignored
      bitcnt <= (bitcnt == 5'(`SPR_FRAME_BITS)) ? bitcnt : bitcnt + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hdr <= 8'h00;
    end else if (!active) begin
      hdr <= 8'h00;
    end else if (hdr_done) begin
      hdr <= rx_byte;
    end
  end

  // ***********************************************
  // registers
  // ***********************************************
  logic [7:0]  pin_cfg;
  logic [3:0]  status;
  logic [3:0]  mask;
  wire  [7:0]  rd_val =
    (rx_byte[6:0] == `SPR_DEV_PINCFG) ? pin_cfg :
    (rx_byte[6:0] == `SPR_DEV_STATUS) ? {4'h0, status} :
    (rx_byte[6:0] == `SPR_DEV_MASK)   ? {4'h0, mask} :
    (rx_byte[6:0] == `SPR_DEV_USER)   ? user_ctrl : 8'h00;
  wire  [3:0]  st_clr    = (wr_en && wr_addr == `SPR_DEV_STATUS) ? rx_byte[3:0] : 4'h0;
  // a new event beats a clear in the same cycle
  wire  [3:0]  next_status = (status & ~st_clr) | event_in;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_cfg   <= `SPR_PINCFG_RST;
      mask      <= 4'h0;
      user_ctrl <= `SPR_USER_RST;
      status    <= 4'h0;
    end else begin
      status <= next_status;
      if (wr_en && wr_addr == `SPR_DEV_PINCFG) begin
        pin_cfg <= rx_byte;
      end
      if (wr_en && wr_addr == `SPR_DEV_MASK) begin
        mask <= rx_byte[3:0];
      end
      if (wr_en && wr_addr == `SPR_DEV_USER) begin
        user_ctrl <= rx_byte;
      end
    end
  end

  // ***********************************************
  // serial data output
  // ***********************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txd         <= 8'h00;
      link.sdo    <= 1'b0;
      link.sdo_oe <= 1'b0;
    end else if (!active) begin
      link.sdo    <= 1'b0;
      link.sdo_oe <= 1'b0;
    end else begin
      link.sdo_oe <= 1'b1;
      if (hdr_done && rx_byte[`SPR_RW_BIT]) begin
        txd <= rd_val;
      end else if (shift_eg && in_data && is_read) begin
        // same bit count works for both phases: the shift edge follows the eighth sample
        link.sdo <= txd[7];
        txd      <= {txd[6:0], 1'b0};
      end
    end
  end

  // ***********************************************
  // interrupt pin
  // ***********************************************
  wire irq_active = |(status & mask);
  wire pin_assert = pin_cfg[`SPR_PIN_GPO] ? pin_cfg[`SPR_PIN_GPOVAL] : irq_active;
  // general output drives its value as the level; polarity applies to interrupts only
  wire pin_level  = pin_cfg[`SPR_PIN_GPO] ? pin_assert
                  : (pin_assert ~^ pin_cfg[`SPR_PIN_POL]);
  wire next_out   = pin_cfg[`SPR_PIN_OD] ? 1'b0 : pin_level;
  wire next_oe    = pin_cfg[`SPR_PIN_OD] ? ~pin_level : 1'b1;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link.irq_out <= 1'b0;
      link.irq_oe  <= 1'b0;
    end else begin
      link.irq_out <= next_out;
      link.irq_oe  <= next_oe;
    end
  end
endmodule // spr_device

// ---- src/spr_host.sv ----
// controller end: serial bus master with software register port
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "spr_map.svh"
module spr_host
  import spr_pkg::*;
#(
  parameter int HALF = `SPR_HALF_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             irq,
  spr_if.host              link
);
  generate
    if (HALF < `SPR_HALF_MIN || HALF > 255) begin : g_bad
      $error("spr_host HALF too short for synchronised turnaround");
    end
  endgenerate

  // ***********************************************
  // pin synchronisation
  // ***********************************************
  logic       miso_s;
  logic       pin_s;
  logic       pin_prev;
  spr_sync #(.WIDTH(2), .INIT(2'h3)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({link.sdo_wire, link.irq_wire}),
    .q     ({miso_s, pin_s})
  );

  // ***********************************************
  // software registers
  // ***********************************************
  spr_hstate_t state;
  logic [1:0]  mode;
  logic [1:0]  status;
  logic [1:0]  mask;
  logic [7:0]  rxdata;
  logic        done_ev;
  wire         busy      = state != H_IDLE;
  wire         start     = wr && addr == `SPR_HST_CMD && !busy;   // busy writes are dropped
  wire  [1:0]  st_clr    = (wr && addr == `SPR_HST_STATUS) ? wdata[1:0] : 2'h0;
  wire  [1:0]  events    = {pin_s ^ pin_prev, done_ev};
  wire  [1:0]  next_status = (status & ~st_clr) | events;
  wire  [15:0] rd_val =
    (addr == `SPR_HST_RXDATA) ? {8'h00, rxdata} :
    (addr == `SPR_HST_STATUS) ? {14'h0000, status} :
    (addr == `SPR_HST_MASK)   ? {14'h0000, mask} :
    (addr == `SPR_HST_MODE)   ? {14'h0000, mode} :
    (addr == `SPR_HST_STATE)  ? {14'h0000, pin_s, busy} : 16'h0000;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode     <= `SPR_MODE_RST;
      mask     <= 2'h0;
      status   <= 2'h0;
      pin_prev <= 1'b1;
      rdata    <= 16'h0000;
      irq      <= 1'b0;
    end else begin
      pin_prev <= pin_s;
      status   <= next_status;
      irq      <= |(next_status & mask);
      rdata    <= rd ? rd_val : 16'h0000;
      // mode changes only between frames so the straps never move mid-transfer
      if (wr && addr == `SPR_HST_MODE && !busy) begin
        mode <= wdata[1:0];
      end
      if (wr && addr == `SPR_HST_MASK) begin
        mask <= wdata[1:0];
      end
    end
  end

  // ***********************************************
  // frame sequencer
  // ***********************************************
  logic [7:0]  tick;
  logic [5:0]  edge_n;
  logic [15:0] txsh;
  logic [7:0]  rxsh;
  wire         half_end  = tick == 8'(HALF - 1);
  wire         lead_eg   = ~edge_n[0];
  wire         sample_eg = lead_eg ^ mode[`SPR_MODE_CPHA];
  wire         shift_eg  = ~sample_eg && edge_n != 6'h00;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state     <= H_IDLE;
      tick      <= 8'h00;
      edge_n    <= 6'h00;
      txsh      <= 16'h0000;
      rxsh      <= 8'h00;
      rxdata    <= 8'h00;
      done_ev   <= 1'b0;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.sdi  <= 1'b0;
      link.cpol <= 1'b0;
      link.cpha <= 1'b0;
    end else begin
      done_ev   <= 1'b0;
      link.cpol <= mode[`SPR_MODE_CPOL];
      link.cpha <= mode[`SPR_MODE_CPHA];
      tick      <= (busy && !half_end) ? tick + 8'h01 : 8'h00;
      unique case (state)
        H_IDLE: begin
          link.sclk <= mode[`SPR_MODE_CPOL];
          if (start) begin
            state     <= H_SETUP;
            link.cs_n <= 1'b0;
            txsh      <= {wdata[15:8], wdata[7:0]};
            link.sdi  <= wdata[15];
            edge_n    <= 6'h00;
          end
        end
        H_SETUP: begin
          if (half_end) begin
            state <= H_RUN;
          end
        end
        H_RUN: begin
          if (half_end) begin
            link.sclk <= ~link.sclk;
            edge_n    <= edge_n + 6'h01;
            if (sample_eg) begin
              rxsh <= {rxsh[6:0], miso_s};
            end
            if (shift_eg) begin
              link.sdi <= txsh[14];
              txsh     <= {txsh[14:0], 1'b0};
            end
            if (edge_n == 6'(2 * `SPR_FRAME_BITS - 1)) begin
              state <= H_HOLD;
            end
          end
        end
        H_HOLD: begin
          if (half_end) begin
            state     <= H_IDLE;
            link.cs_n <= 1'b1;
            rxdata    <= rxsh;
            done_ev   <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule // spr_host

// ---- tb/spr_assertions.sv ----
// concurrent checks on the serial link between controller and device
`timescale 1ns/1ps
module spr_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic cpol,
  input wire logic cpha
);
  logic       sclk_q;
  logic [7:0] edge_cnt;
  logic       samp_edge;

  // sample edge: rising when polarity equals phase
  assign samp_edge = (cpol == cpha) ? (sclk && !sclk_q) : (!sclk && sclk_q);

  // counts clock edges inside a frame, cleared while deselected
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_q   <= 1'b0;
      edge_cnt <= 8'h00;
    end else begin
      sclk_q   <= sclk;
      edge_cnt <= cs_n ? 8'h00 : edge_cnt + {7'h00, sclk != sclk_q};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_idle_at_start: assert property ($fell(cs_n) |-> sclk == cpol)
    else $error("serial clock not idle at frame start");
  a_idle_at_end: assert property ($rose(cs_n) |-> sclk == cpol)
    else $error("serial clock not idle at frame end");
  a_edge_count: assert property ($rose(cs_n) |-> edge_cnt == 8'h20)
    else $error("frame does not hold 32 clock edges");
  a_straps_stable: assert property (!cs_n |-> $stable(cpol) && $stable(cpha))
    else $error("clock mode changed inside a frame");
  a_sdi_settled: assert property (!cs_n && samp_edge |-> $stable(sdi) ##1 $stable(sdi))
    else $error("input data moved at its sample edge");
  a_sdo_settled: assert property (!cs_n && sdo_oe && samp_edge |-> $stable(sdo))
    else $error("output data moved at its sample edge");
  a_half_period: assert property ($changed(sclk) |=> $stable(sclk) [*5])
    else $error("serial clock half period too short");
  a_sdo_off_idle: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("data output driven while deselected");
  a_sdo_release: assert property ($rose(cs_n) |-> ##[1:4] !sdo_oe)
    else $error("data output not released after frame");
endmodule // spr_assertions

// ---- tb/tb_top.sv ----
// self-checking bench: controller and device joined over the serial link
`timescale 1ns/1ps
`include "spr_map.svh"
module tb_top;
  logic        clk;
  logic        reset;
  logic        spi_mode_en;
  logic        wr;
  logic        rd;
  logic [3:0]  addr;
  logic [3:0]  event_in;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] v;
  logic        irq;
  logic [7:0]  user_ctrl;
  int          failures;
  int          n_compared;
  int          cycles;
  // rows: clock mode, byte written and expected back
  logic [9:0]  rows [4] = '{10'h0A5, 10'h13C, 10'h2FF, 10'h301};
  // pin rows: expected wire level, pin config byte
  logic [8:0]  pins [5] = '{9'h000, 9'h103, 9'h002, 9'h004, 9'h10C};

  spr_if link_if ();
  spr_host #(.HALF(6)) u_spr_host (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .link(link_if.host));
  spr_device u_spr_device (.clk(clk), .reset(reset), .spi_mode_en(spi_mode_en), .event_in(event_in),
    .user_ctrl(user_ctrl), .link(link_if.dev));
  spr_assertions u_spr_assertions (.clk(clk), .reset(reset), .cs_n(link_if.cs_n), .sclk(link_if.sclk),
    .sdi(link_if.sdi), .sdo(link_if.sdo), .sdo_oe(link_if.sdo_oe), .cpol(link_if.cpol), .cpha(link_if.cpha));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ********
  // tasks
  // ********
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task bus_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // bounded poll of busy; a hang shows as a busy mismatch
  task wait_idle();
    int k;
    k = 0;
    v = 16'h0001;
    while (v[0] !== 1'b0 && k < 400) begin
      bus_rd(`SPR_HST_STATE);
      k++;
    end
    chk(v & 16'h0001, 16'h0000);
  endtask

  task frm(input logic rw, input logic [6:0] a, input logic [7:0] d);
    bus_wr(`SPR_HST_CMD, {rw, a, d});
    wait_idle();
  endtask

  task stop_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      stop_test();
    end
  end

  // ********
  // sequence
  // ********
  initial begin
    reset = 1'b1;
    spi_mode_en = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    event_in = 4'h0;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus_wr(`SPR_HST_MODE, {14'h0000, rows[i][9:8]});
      frm(1'b0, `SPR_DEV_USER, rows[i][7:0]);
      chk({8'h00, user_ctrl}, {8'h00, rows[i][7:0]});
      frm(1'b1, `SPR_DEV_USER, 8'h00);
      bus_rd(`SPR_HST_RXDATA);
      chk(v, {8'h00, rows[i][7:0]});
    end
    frm(1'b1, 7'h7F, 8'h00);
    bus_rd(`SPR_HST_RXDATA);
    chk(v, 16'h0000);
    bus_rd(4'hF);
    chk(v, 16'h0000);
    // mode write while busy must be dropped
    bus_wr(`SPR_HST_CMD, {1'b1, `SPR_DEV_USER, 8'h00});
    bus_wr(`SPR_HST_MODE, 16'h0000);
    wait_idle();
    bus_rd(`SPR_HST_MODE);
    chk(v, 16'h0003);
    // controller interrupt: raised, cleared, masked
    bus_wr(`SPR_HST_STATUS, 16'h0003);
    bus_wr(`SPR_HST_MASK, 16'h0001);
    frm(1'b0, `SPR_DEV_USER, 8'h01);
    chk({15'h0000, irq}, 16'h0001);
    bus_rd(`SPR_HST_STATUS);
    chk(v, 16'h0001);
    bus_wr(`SPR_HST_STATUS, 16'h0001);
    @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    bus_wr(`SPR_HST_MASK, 16'h0000);
    frm(1'b0, `SPR_DEV_USER, 8'h01);
    chk({15'h0000, irq}, 16'h0000);
    // device pin: pending event under each drive style
    frm(1'b0, `SPR_DEV_MASK, 8'h01);
    @(posedge clk);
    event_in <= 4'h1;
    @(posedge clk);
    event_in <= 4'h0;
    repeat (4) @(posedge clk);
    chk({15'h0000, link_if.irq_wire}, 16'h0001);
    for (int j = 0; j < 5; j++) begin
      frm(1'b0, `SPR_DEV_PINCFG, pins[j][7:0]);
      chk({15'h0000, link_if.irq_wire}, {15'h0000, pins[j][8]});
    end
    bus_rd(`SPR_HST_STATUS);
    chk(v & 16'h0002, 16'h0002);
    // device status and mask read back over the link, then the status cleared over the link
    frm(1'b1, `SPR_DEV_STATUS, 8'h00);
    bus_rd(`SPR_HST_RXDATA);
    chk(v, 16'h0001);
    frm(1'b1, `SPR_DEV_MASK, 8'h00);
    bus_rd(`SPR_HST_RXDATA);
    chk(v, 16'h0001);
    frm(1'b0, `SPR_DEV_PINCFG, 8'h02);
    frm(1'b0, `SPR_DEV_STATUS, 8'h01);
    chk({15'h0000, link_if.irq_wire}, 16'h0001);
    bus_rd(`SPR_HST_STATE);
    chk(v, 16'h0002);
    // serial mode off: pins ignored, output floats high
    @(posedge clk);
    spi_mode_en <= 1'b0;
    frm(1'b0, `SPR_DEV_USER, 8'h55);
    chk({8'h00, user_ctrl}, 16'h0001);
    frm(1'b1, `SPR_DEV_USER, 8'h00);
    bus_rd(`SPR_HST_RXDATA);
    chk(v, 16'h00FF);
    @(posedge clk);
    spi_mode_en <= 1'b1;
    // reset in mid-frame, then a clean frame from bit zero
    bus_wr(`SPR_HST_CMD, {1'b0, `SPR_DEV_USER, 8'hAA});
    repeat (50) @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h00, link_if.cs_n, user_ctrl}, 16'h0100);
    reset <= 1'b0;
    frm(1'b1, `SPR_DEV_PINCFG, 8'h00);
    bus_rd(`SPR_HST_RXDATA);
    chk(v, 16'h0001);
    stop_test();
  end
endmodule // tb_top
